// ===== hw/csd_defines.svh
// Constants and timing counts for the card sideband and sleep detect block.
`ifndef CSD_DEFINES_SVH
`define CSD_DEFINES_SVH
`define CSD_CLK_MHZ 250
`define CSD_WAKE_MIN_US 2000
`define CSD_WAKE_CYCLES (`CSD_WAKE_MIN_US * `CSD_CLK_MHZ)
`define CSD_CNT_W 20
`endif

// ===== hw/csd_pkg.sv
// Types for the card sideband and sleep detect block.
package csd_pkg;
    typedef enum logic [2:0] {
        CSD_ST_ACTIVE = 3'b000,
        CSD_ST_SLEEP = 3'b001,
        CSD_ST_LOW_TIMING = 3'b010,
        CSD_ST_WAKE_WAIT = 3'b011,
        CSD_ST_WAKE = 3'b100
    } csd_state_t;
endpackage

// ===== hw/csd_low_timer.sv
// Low-period timer for the synchronised card-detect level.
`timescale 1ns/1ns
`include "csd_defines.svh"
module csd_low_timer #(
    parameter int CNT_W = `CSD_CNT_W,
    parameter int LIMIT = `CSD_WAKE_CYCLES
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic run,
    output logic reached
);
    logic [CNT_W-1:0] count_ff;
    logic [CNT_W-1:0] nxt_count;
    localparam logic [CNT_W-1:0] LIMIT_M1 = CNT_W'(LIMIT - 1);

    initial begin
        if (LIMIT < 2 || LIMIT >= (1 << CNT_W)) begin
            $error("csd_low_timer: LIMIT does not fit CNT_W");
        end
    end

    // Counter saturates at LIMIT_M1 so a long assertion cannot wrap back below it.
    assign nxt_count = !run ? '0 : (count_ff == LIMIT_M1) ? count_ff : count_ff + 1'b1;
    assign reached = run && (count_ff == LIMIT_M1);

    always_ff @(posedge mclk) begin
        if (srst) begin
            count_ff <= '0;
        end else begin
            count_ff <= nxt_count;
        end
    end
endmodule

// ===== hw/csd_sideband.sv
// Card sideband logic: indicators, write protect, card-detect sensing and PHY sleep control.
// Contract
// - Activity indicator low while command busy.
// - Link indicator low while link active.
// - Write protect low rejects all writes.
// - Card-detect pins form one sensed net.
// - Never drive the card-detect net.
// - PHY fully off during sleep from Slumber.
// - Short low pulses keep sleep state.
// - Power down PHY, keep calibration, on entry.
// - Wake only on low of two milliseconds.
// - Send COMWAKE after PHY power-up.
`timescale 1ns/1ns
`include "csd_defines.svh"
module csd_sideband #(
    parameter int WAKE_CYCLES = `CSD_WAKE_CYCLES,
    parameter int CNT_W = `CSD_CNT_W
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic cmd_busy,
    input wire logic link_active,
    input wire logic link_slumber,
    input wire logic write_protect_n,
    input wire logic cmd_is_write,
    input wire logic cmd_valid,
    input wire logic card_detect_in,
    output logic card_detect_oe,
    output logic card_detect_sensed,
    output logic activity_indicator_n,
    output logic activity_indicator_oe,
    output logic link_indicator_n,
    output logic link_indicator_oe,
    output logic write_reject,
    output logic media_write_protected,
    output logic phy_sleep_mode,
    output logic phy_power_en,
    output logic phy_keep_calibration,
    output logic comwake_req
);
    // ------------------------------------------------------------
    // Parameter checks
    // ------------------------------------------------------------
    // The low timer needs at least two counts, and it must hold the limit in
    // CNT_W bits. A timer that wrapped early would let presence probes wake
    // the card, which is the one thing the sleep logic has to prevent.
    initial begin
        if (WAKE_CYCLES < 2) begin
            $error("csd_sideband: WAKE_CYCLES must be at least 2");
        end
        if (CNT_W < 2 || CNT_W > 31) begin
            $error("csd_sideband: CNT_W out of range");
        end
        if (CNT_W <= 31 && WAKE_CYCLES >= (1 << CNT_W)) begin
            $error("csd_sideband: WAKE_CYCLES does not fit CNT_W");
        end
    end

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    // Both pins arrive from outside this clock. Only the second stage of each
    // pair is read by logic, so a metastable first stage never fans out.
    // The card-detect pair resets low because the host holds the net low in
    // normal use; resetting it high would look like a sleep request.
    // The protect pair resets high, which means not protected.
    logic cd_meta_ff, cd_sync_ff;
    logic wp_meta_ff, wp_sync_ff;

    always_ff @(posedge mclk) begin
        if (srst) begin
            cd_meta_ff <= 1'b0;
            cd_sync_ff <= 1'b0;
            wp_meta_ff <= 1'b1;
            wp_sync_ff <= 1'b1;
        end else begin
            cd_meta_ff <= card_detect_in;
            cd_sync_ff <= cd_meta_ff;
            wp_meta_ff <= write_protect_n;
            wp_sync_ff <= wp_meta_ff;
        end
    end

    // The card-detect net is sense-only; the enable stays low forever.
    assign card_detect_oe = 1'b0;

    // ------------------------------------------------------------
    // Indicators and write protect
    // ------------------------------------------------------------
    // Indicator and protect outputs are registered so the pins see one clean
    // edge per change. The reject pulse uses the same protect flag that is
    // reported outward, so a write is never rejected while the card reports
    // itself writable, nor accepted while it reports itself protected.
    logic act_ff, link_ff, wp_ff, reject_ff;
    wire wr_attempt = cmd_valid && cmd_is_write;

    always_ff @(posedge mclk) begin
        if (srst) begin
            act_ff <= 1'b0;
            link_ff <= 1'b0;
            wp_ff <= 1'b0;
            reject_ff <= 1'b0;
        end else begin
            act_ff <= cmd_busy;
            link_ff <= link_active;
            wp_ff <= !wp_sync_ff;
            reject_ff <= wr_attempt && wp_ff;
        end
    end

    // Indicators only pull low; released means output enable off, pulled up weakly outside.
    assign activity_indicator_n = 1'b0;
    assign activity_indicator_oe = act_ff;
    assign link_indicator_n = 1'b0;
    assign link_indicator_oe = link_ff;
    assign media_write_protected = wp_ff;
    assign write_reject = reject_ff;

    // ------------------------------------------------------------
    // PHY sleep state machine
    // ------------------------------------------------------------
    csd_pkg::csd_state_t state_ff, nxt_state;
    logic cd_sensed_ff;
    logic timer_run, timer_reached;

    csd_low_timer #(.CNT_W(CNT_W), .LIMIT(WAKE_CYCLES)) u_timer (
        .mclk(mclk),
        .srst(srst),
        .run(timer_run),
        .reached(timer_reached)
    );

    // Timer runs only while a low is seen during sleep; any high restarts it.
    assign timer_run = (state_ff == csd_pkg::CSD_ST_LOW_TIMING) && !cd_sync_ff;

    // Sleep is entered from the active state only. Once asleep, every low on
    // the net is timed; a low that ends before the limit is a presence probe
    // and drops back to plain sleep. A low that reaches the limit passes
    // through one settling state and then the wake state, which raises the
    // one-cycle wake request. A limitation: if the link still sits in Slumber
    // with the net high after a wake, sleep is entered again.
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            csd_pkg::CSD_ST_ACTIVE: begin
                // Entry only while the link sits in Slumber and the host released the net.
                if (link_slumber && cd_sync_ff) begin
                    nxt_state = csd_pkg::CSD_ST_SLEEP;
                end
            end
            csd_pkg::CSD_ST_SLEEP: begin
                if (!cd_sync_ff) begin
                    nxt_state = csd_pkg::CSD_ST_LOW_TIMING;
                end
            end
            csd_pkg::CSD_ST_LOW_TIMING: begin
                // A high before the limit ends the probe; the timer restarts
                // from zero on the next low, so short lows never add up.
                if (cd_sync_ff) begin
                    nxt_state = csd_pkg::CSD_ST_SLEEP;
                end else if (timer_reached) begin
                    nxt_state = csd_pkg::CSD_ST_WAKE_WAIT;
                end
            end
            csd_pkg::CSD_ST_WAKE_WAIT: begin
                nxt_state = csd_pkg::CSD_ST_WAKE;
            end
            csd_pkg::CSD_ST_WAKE: begin
                nxt_state = csd_pkg::CSD_ST_ACTIVE;
            end
            default: begin
                nxt_state = csd_pkg::CSD_ST_ACTIVE;
            end
        endcase
    end

    // The PHY counts as asleep both while idle in sleep and while a low is
    // being timed, so a short presence probe never powers the PHY back up.
    wire nxt_asleep = (nxt_state == csd_pkg::CSD_ST_SLEEP) || (nxt_state == csd_pkg::CSD_ST_LOW_TIMING);
    wire nxt_wake_pulse = (nxt_state == csd_pkg::CSD_ST_WAKE);

    logic sleep_ff, wake_ff;

    always_ff @(posedge mclk) begin
        if (srst) begin
            state_ff <= csd_pkg::CSD_ST_ACTIVE;
            cd_sensed_ff <= 1'b0;
            sleep_ff <= 1'b0;
            wake_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cd_sensed_ff <= cd_sync_ff;
            sleep_ff <= nxt_asleep;
            wake_ff <= nxt_wake_pulse;
        end
    end

    // ------------------------------------------------------------
    // PHY control outputs
    // ------------------------------------------------------------
    // Power follows the sleep flag directly, so the PHY is switched off in the
    // same cycle that sleep is reported and back on as soon as the wake is
    // accepted. The wake request is one cycle long; the link layer starts its
    // wake signalling from that pulse and must not need it held.
    // The sensed level is delayed one more register so that it lines up with
    // the state machine, which reads the same synchronised level.
    assign card_detect_sensed = cd_sensed_ff;
    assign phy_sleep_mode = sleep_ff;
    assign phy_power_en = !sleep_ff;
    // Calibration is kept at all times so the wake needs no recalibration.
    assign phy_keep_calibration = 1'b1;
    assign comwake_req = wake_ff;
endmodule

// ===== verification/csd_sideband_assertions.sv
// Assertions for the card sideband block.
`timescale 1ns/1ns
module csd_sideband_assertions #(parameter int WAKE_CYCLES = 20) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic cmd_busy,
    input wire logic link_active,
    input wire logic link_slumber,
    input wire logic cmd_valid,
    input wire logic cmd_is_write,
    input wire logic card_detect_in,
    input wire logic card_detect_oe,
    input wire logic activity_indicator_oe,
    input wire logic link_indicator_oe,
    input wire logic write_reject,
    input wire logic media_write_protected,
    input wire logic phy_sleep_mode,
    input wire logic phy_power_en,
    input wire logic comwake_req
);
    int low_ff;
    default clocking @(posedge mclk); endclocking
    default disable iff srst;
    // Raw low run length, so a wake can be tied to the pulse that caused it.
    always_ff @(posedge mclk) low_ff <= (srst || card_detect_in) ? 0 : low_ff + 1;
    sequence s_enter;
        $rose(card_detect_in) && link_slumber && !phy_sleep_mode ##1 (card_detect_in && link_slumber)[*4];
    endsequence
    AST_ACT: assert property (1 |=> activity_indicator_oe == $past(cmd_busy)) else $error("act");
    AST_LINK: assert property (1 |=> link_indicator_oe == $past(link_active)) else $error("link");
    AST_WP: assert property (cmd_valid && cmd_is_write && media_write_protected |=> write_reject) else $error("wp");
    AST_CDOE: assert property (!card_detect_oe) else $error("cd driven");
    AST_PWR: assert property (phy_power_en != phy_sleep_mode) else $error("pwr");
    AST_ENTER: assert property (s_enter |-> ##[0:2] phy_sleep_mode) else $error("enter");
    AST_WAKE: assert property ($fell(phy_sleep_mode) |-> low_ff >= WAKE_CYCLES && low_ff <= WAKE_CYCLES + 6)
        else $error("wake");
    AST_CW: assert property ($fell(phy_sleep_mode) |-> ##[0:3] comwake_req ##1 !comwake_req) else $error("cw");
endmodule
bind csd_sideband csd_sideband_assertions #(.WAKE_CYCLES(WAKE_CYCLES)) u_csd_chk (.*);

// ===== verification/csd_host_model.sv
// Host side of the card-detect-in pin.
`timescale 1ns/1ns
module csd_host_model (
    input wire logic link_slumber,
    input wire logic sleep_req,
    input wire logic probe,
    output wire logic card_detect_in
);
    // Active output: low in normal use, high only when parked after Slumber.
    assign card_detect_in = sleep_req && link_slumber && !probe;
endmodule

// ===== verification/card_sideband_sleep_detect_test.sv
// Self-checking bench for the card sideband block.
`timescale 1ns/1ns
module card_sideband_sleep_detect_test;
    localparam int W = 20;
    logic mclk, srst, cmd_busy, link_active, link_slumber, write_protect_n, cmd_is_write, cmd_valid;
    logic card_detect_in, card_detect_oe, card_detect_sensed, activity_indicator_n, activity_indicator_oe;
    logic link_indicator_n, link_indicator_oe, write_reject, media_write_protected, phy_sleep_mode;
    logic phy_power_en, phy_keep_calibration, comwake_req, sleep_req, probe;
    int fails = 0;
    int n_tests = 0;
    csd_sideband #(.WAKE_CYCLES(W)) u_csd_sideband (.*);
    csd_host_model u_csd_host_model (.*);
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic chk(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t mismatch", $time);
        end
    endtask
    task automatic end_sim();
        if (fails == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic t_ind();
        cmd_busy = 1'b1;
        link_active = 1'b1;
        tick(1);
        chk(activity_indicator_oe, 1'b1);
        chk(activity_indicator_n, 1'b0);
        cmd_busy = 1'b0;
        tick(1);
        chk(activity_indicator_oe, 1'b0);
        chk(link_indicator_oe, 1'b1);
        link_active = 1'b0;
        tick(1);
        chk(link_indicator_oe, 1'b0);
    endtask
    task automatic t_wp();
        write_protect_n = 1'b0;
        tick(4);
        chk(media_write_protected, 1'b1);
        {cmd_valid, cmd_is_write} = 2'h3;
        tick(1);
        chk(write_reject, 1'b1);
        cmd_is_write = 1'b0;
        tick(1);
        chk(write_reject, 1'b0);
        {cmd_valid, write_protect_n} = 2'h1;
        tick(4);
        {cmd_valid, cmd_is_write} = 2'h3;
        tick(1);
        chk(write_reject, 1'b0);
        cmd_valid = 1'b0;
    endtask
    task automatic t_sleep();
        int i;
        {link_slumber, sleep_req} = 2'h3;
        tick(7);
        chk(phy_sleep_mode, 1'b1);
        chk(phy_power_en, 1'b0);
        probe = 1'b1;
        tick(W - 4);
        chk(card_detect_sensed, 1'b0);
        probe = 1'b0;
        tick(4);
        chk(phy_sleep_mode, 1'b1);
        sleep_req = 1'b0;
        for (i = 0; i < W + 20 && comwake_req !== 1'b1; i++) tick(1);
        chk(comwake_req, 1'b1);
        if (comwake_req !== 1'b1) end_sim();
        chk(phy_power_en, 1'b1);
        chk(phy_keep_calibration, 1'b1);
        chk(card_detect_oe, 1'b0);
    endtask
    initial begin
        srst = 1'b1;
        {cmd_busy, link_active, link_slumber, cmd_is_write, cmd_valid, sleep_req, probe} = 7'h00;
        write_protect_n = 1'b1;
        tick(7);
        chk(phy_power_en, 1'b1);
        chk(phy_sleep_mode, 1'b0);
        chk(comwake_req, 1'b0);
        chk(card_detect_oe, 1'b0);
        srst = 1'b0;
        tick(3);
        t_ind();
        t_wp();
        t_sleep();
        end_sim();
    end
endmodule
